// ===== sfc_pkg.sv
// Purpose: shared constants and types for the serial fifo configuration block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package sfc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] FIFO_CONFIGURATION_OFS = 8'h00;
  localparam logic [7:0] MODE_CONTROL_OFS       = 8'h04;
  localparam logic [7:0] RX_FIFO_CONTROL_OFS    = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS         = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_OFS         = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_OFS          = 8'h14;
  localparam logic [7:0] DIRECTION_STATUS_OFS   = 8'h18;

  // ==========================================================
  // fifo_configuration fields
  localparam int FCFG_FIFO_ENABLE_BIT   = 0;
  localparam int FCFG_AUTO_DISABLE_BIT  = 1;
  localparam int FCFG_RX_IRQ_EN_BIT     = 2;
  localparam int FCFG_TX_IRQ_EN_BIT     = 3;
  localparam int FCFG_RX_USAGE_BIT      = 4;
  localparam logic [4:0] FCFG_RESET     = 5'h00;

  // mode control fields
  localparam int MODE_RX_ENABLE_BIT     = 0;
  localparam int MODE_TX_ENABLE_BIT     = 1;
  localparam int MODE_DUPLEX_LSB        = 2;
  localparam int MODE_NINE_BIT_BIT      = 4;
  localparam logic [4:0] MODE_RESET     = 5'h00;

  // rx fifo control fields
  localparam int RFC_FILL_LSB           = 0;
  localparam int RFC_CLEAR_BIT          = 7;
  localparam logic [1:0] RFC_RESET      = 2'h0;

  // irq status bits
  localparam int IRQ_TX_BIT             = 0;
  localparam int IRQ_RX_BIT             = 1;
  localparam logic [1:0] IRQ_RESET      = 2'h0;

  // ==========================================================
  // depths in bytes
  localparam logic [2:0] DEPTH_WHOLE    = 3'h4;
  localparam logic [2:0] DEPTH_HALF     = 3'h2;
  localparam logic [2:0] DEPTH_NONE     = 3'h0;

  typedef enum logic [1:0] {
    SFC_DPX_OFF  = 2'h0,
    SFC_DPX_HRX  = 2'h1,
    SFC_DPX_HTX  = 2'h2,
    SFC_DPX_FULL = 2'h3
  } sfc_duplex_type;

  typedef struct packed {
    logic       rx_usage_select;
    logic       tx_fifo_irq_enable;
    logic       rx_fifo_irq_enable;
    logic       auto_direction_disable;
    logic       fifo_enable;
  } sfc_fcfg_type;

  typedef struct packed {
    logic [2:0] rx_depth;
    logic [2:0] tx_depth;
  } sfc_alloc_type;

endpackage

// ===== sfc_alloc.sv
// Purpose: fifo depth allocation from duplex mode and fill level
// Assumes: registered outputs
// Notes:   one cycle latency
`timescale 1ns/10ps
module sfc_alloc (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   fifo_enable,
  input  wire logic                   rx_usage_select,
  input  wire sfc_pkg::sfc_duplex_type duplex,
  input  wire logic [1:0]             fill_level,
  output sfc_pkg::sfc_alloc_type      alloc
);

  // ==========================================================
  // fill level to byte count
  function automatic logic [2:0] fill_bytes(input logic [1:0] lvl, input logic full);
    logic [2:0] res;
    res = 3'h0;
    case (lvl)
      2'h0: res = full ? sfc_pkg::DEPTH_HALF : sfc_pkg::DEPTH_WHOLE;
      2'h1: res = 3'h1;
      2'h2: res = 3'h2;
      default: res = full ? 3'h1 : 3'h3;
    endcase
    return res;
  endfunction

  sfc_pkg::sfc_alloc_type alloc_nxt;

  always_comb begin
    alloc_nxt = '{rx_depth: sfc_pkg::DEPTH_NONE, tx_depth: sfc_pkg::DEPTH_NONE};
    if (fifo_enable) begin
      case (duplex)
        sfc_pkg::SFC_DPX_HRX: alloc_nxt.rx_depth = sfc_pkg::DEPTH_WHOLE;
        sfc_pkg::SFC_DPX_HTX: alloc_nxt.tx_depth = sfc_pkg::DEPTH_WHOLE;
        sfc_pkg::SFC_DPX_FULL: begin
          alloc_nxt.rx_depth = sfc_pkg::DEPTH_HALF;
          alloc_nxt.tx_depth = sfc_pkg::DEPTH_HALF;
        end
        default: alloc_nxt = alloc_nxt;
      endcase
      if (rx_usage_select && alloc_nxt.rx_depth != sfc_pkg::DEPTH_NONE) begin
        alloc_nxt.rx_depth = fill_bytes(fill_level, duplex == sfc_pkg::SFC_DPX_FULL);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alloc <= '{rx_depth: sfc_pkg::DEPTH_NONE, tx_depth: sfc_pkg::DEPTH_NONE};
    end else begin
      alloc <= alloc_nxt;
    end
  end

endmodule

// ===== sfc_top.sv
// Purpose: fifo configuration, irq gating and auto direction disable
// Assumes: apb slave, single 200 MHz clock, synchronous active-low reset
// Notes:   channel event inputs are same-clock one-cycle pulses
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module sfc_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_fifo_event,
  input  wire logic        rx_fifo_event,
  input  wire logic        rx_full_done,
  input  wire logic        tx_end_done,
  output logic             rx_enable,
  output logic             tx_enable,
  output logic             fifo_active,
  output logic      [2:0]  rx_fifo_depth,
  output logic      [2:0]  tx_fifo_depth,
  output logic             rx_fifo_flush,
  output logic             irq
);

  // ==========================================================
  // state
  sfc_pkg::sfc_fcfg_type   fcfg_r;
  sfc_pkg::sfc_duplex_type duplex_r;
  sfc_pkg::sfc_alloc_type  alloc;
  logic                    nine_bit_r;
  logic [1:0]              fill_level_r;
  logic [1:0]              irq_status_r;
  logic [1:0]              irq_enable_r;
  logic [1:0]              irq_events;
  logic                    wr_access;
  logic                    rd_access;
  logic                    rx_stop;
  logic                    tx_stop;
  logic [31:0]             prdata_nxt;
  logic                    pslverr_nxt;

  typedef enum logic [1:0] {
    SFC_BUS_IDLE = 2'b01,
    SFC_BUS_DONE = 2'b10
  } sfc_bus_type;

  sfc_bus_type bus_r;

  // ==========================================================
  // address decode
  function automatic logic known_addr(input logic [7:0] a);
    case (a)
      sfc_pkg::FIFO_CONFIGURATION_OFS,
      sfc_pkg::MODE_CONTROL_OFS,
      sfc_pkg::RX_FIFO_CONTROL_OFS,
      sfc_pkg::IRQ_STATUS_OFS,
      sfc_pkg::IRQ_ENABLE_OFS,
      sfc_pkg::IRQ_CLEAR_OFS,
      sfc_pkg::DIRECTION_STATUS_OFS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  assign wr_access = psel && penable && pwrite && bus_r == SFC_BUS_IDLE;
  assign rd_access = psel && penable && !pwrite && bus_r == SFC_BUS_IDLE;

  // ==========================================================
  // apb handshake: one wait state, answer in second access cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_r  <= SFC_BUS_IDLE;
      pready <= 1'b0;
    end else begin
      case (bus_r)
        SFC_BUS_IDLE: begin
          if (psel && penable) begin
            bus_r  <= SFC_BUS_DONE;
            pready <= 1'b1;
          end
        end
        SFC_BUS_DONE: begin
          bus_r  <= SFC_BUS_IDLE;
          pready <= 1'b0;
        end
        default: begin
          bus_r  <= SFC_BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = !known_addr(paddr);
    case (paddr)
      sfc_pkg::FIFO_CONFIGURATION_OFS: prdata_nxt[4:0] = fcfg_r;
      sfc_pkg::MODE_CONTROL_OFS: begin
        prdata_nxt[sfc_pkg::MODE_RX_ENABLE_BIT] = rx_enable;
        prdata_nxt[sfc_pkg::MODE_TX_ENABLE_BIT] = tx_enable;
        prdata_nxt[sfc_pkg::MODE_DUPLEX_LSB +: 2] = duplex_r;
        prdata_nxt[sfc_pkg::MODE_NINE_BIT_BIT] = nine_bit_r;
      end
      sfc_pkg::RX_FIFO_CONTROL_OFS: begin
        prdata_nxt[sfc_pkg::RFC_FILL_LSB +: 2] = fill_level_r;
      end
      sfc_pkg::IRQ_STATUS_OFS: prdata_nxt[1:0] = irq_status_r;
      sfc_pkg::IRQ_ENABLE_OFS: prdata_nxt[1:0] = irq_enable_r;
      sfc_pkg::DIRECTION_STATUS_OFS: prdata_nxt[5:0] = {alloc.rx_depth, alloc.tx_depth};
      default: prdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_access || wr_access) begin
      prdata  <= rd_access ? prdata_nxt : 32'h0000_0000;
      pslverr <= pslverr_nxt;
    end else if (bus_r == SFC_BUS_DONE) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // fifo configuration register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fcfg_r <= sfc_pkg::FCFG_RESET;
    end else if (wr_access && paddr == sfc_pkg::FIFO_CONFIGURATION_OFS) begin
      fcfg_r <= pwdata[4:0];
    end
  end

  // ==========================================================
  // mode control and direction enables
  assign rx_stop = fcfg_r.auto_direction_disable && rx_full_done;
  assign tx_stop = fcfg_r.auto_direction_disable && tx_end_done;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      duplex_r   <= sfc_pkg::SFC_DPX_OFF;
      nine_bit_r <= 1'b0;
    end else if (wr_access && paddr == sfc_pkg::MODE_CONTROL_OFS) begin
      duplex_r   <= sfc_pkg::sfc_duplex_type'(pwdata[sfc_pkg::MODE_DUPLEX_LSB +: 2]);
      nine_bit_r <= pwdata[sfc_pkg::MODE_NINE_BIT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
    end else begin
      if (wr_access && paddr == sfc_pkg::MODE_CONTROL_OFS) begin
        rx_enable <= pwdata[sfc_pkg::MODE_RX_ENABLE_BIT];
        tx_enable <= pwdata[sfc_pkg::MODE_TX_ENABLE_BIT];
      end
      // hardware clear wins over a same-cycle write
      case (duplex_r)
        sfc_pkg::SFC_DPX_HRX: if (rx_stop) rx_enable <= 1'b0;
        sfc_pkg::SFC_DPX_HTX: if (tx_stop) tx_enable <= 1'b0;
        sfc_pkg::SFC_DPX_FULL: begin
          if (rx_stop || tx_stop) begin
            rx_enable <= 1'b0;
            tx_enable <= 1'b0;
          end
        end
        default: begin
          if (rx_stop) rx_enable <= 1'b0;
          if (tx_stop) tx_enable <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // rx fifo control: fill level and self-clearing flush
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fill_level_r  <= sfc_pkg::RFC_RESET;
      rx_fifo_flush <= 1'b0;
    end else begin
      rx_fifo_flush <= 1'b0;
      if (wr_access && paddr == sfc_pkg::RX_FIFO_CONTROL_OFS) begin
        fill_level_r  <= pwdata[sfc_pkg::RFC_FILL_LSB +: 2];
        rx_fifo_flush <= pwdata[sfc_pkg::RFC_CLEAR_BIT];
      end
    end
  end

  // ==========================================================
  // fifo allocation
  sfc_alloc u_alloc (
    .clk             (clk),
    .reset_n         (reset_n),
    .fifo_enable     (fcfg_r.fifo_enable),
    .rx_usage_select (fcfg_r.rx_usage_select),
    .duplex          (duplex_r),
    .fill_level      (fill_level_r),
    .alloc           (alloc)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fifo_active   <= 1'b0;
      rx_fifo_depth <= sfc_pkg::DEPTH_NONE;
      tx_fifo_depth <= sfc_pkg::DEPTH_NONE;
    end else begin
      fifo_active   <= fcfg_r.fifo_enable && !nine_bit_r;
      rx_fifo_depth <= alloc.rx_depth;
      tx_fifo_depth <= alloc.tx_depth;
    end
  end

  // ==========================================================
  // interrupts
  always_comb begin
    irq_events = 2'h0;
    irq_events[sfc_pkg::IRQ_TX_BIT] = fcfg_r.fifo_enable && fcfg_r.tx_fifo_irq_enable
                                      && tx_fifo_event;
    irq_events[sfc_pkg::IRQ_RX_BIT] = fcfg_r.fifo_enable && fcfg_r.rx_fifo_irq_enable
                                      && rx_fifo_event;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_status_r <= sfc_pkg::IRQ_RESET;
    end else if (wr_access && paddr == sfc_pkg::IRQ_CLEAR_OFS) begin
      irq_status_r <= (irq_status_r & ~pwdata[1:0]) | irq_events;
    end else begin
      irq_status_r <= irq_status_r | irq_events;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_enable_r <= sfc_pkg::IRQ_RESET;
    end else if (wr_access && paddr == sfc_pkg::IRQ_ENABLE_OFS) begin
      irq_enable_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_enable_r);
    end
  end

endmodule

// ===== sfc_top_properties.sv
// Purpose: port-level checks for sfc_top
// Assumes: apb requests held until pready
// Notes:   shadows config, duplex and irq enable
`timescale 1ns/10ps
module sfc_top_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        tx_fifo_event,
  input wire logic        rx_fifo_event,
  input wire logic        rx_full_done,
  input wire logic        tx_end_done,
  input wire logic        rx_enable,
  input wire logic        tx_enable,
  input wire logic        fifo_active,
  input wire logic        rx_fifo_flush,
  input wire logic        irq,
  input wire logic [2:0]  rx_fifo_depth,
  input wire logic [2:0]  tx_fifo_depth
);
  // ======
  // register shadows
  logic       tk, wr;
  logic [4:0] cfg_r;
  logic [2:0] mode_r;
  logic [1:0] ien_r, age_r;
  assign tk = psel && penable && !pready;
  assign wr = tk && pwrite;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_r  <= 5'h00;
      mode_r <= 3'h0;
      ien_r  <= 2'h0;
      age_r  <= 2'h0;
    end else begin
      if (wr && paddr == 8'h00) cfg_r <= pwdata[4:0];
      if (wr && paddr == 8'h04) mode_r <= pwdata[4:2];
      if (wr && paddr == 8'h10) ien_r <= pwdata[1:0];
      if (wr) age_r <= 2'h0;
      else if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
  end
  // ======
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_apb_wait: assert property (tk |=> pready ##1 !pready)
    else $error("pready not single after one wait");
  chk_flush_pulse: assert property (
    wr && paddr == 8'h08 && pwdata[7] |-> ##[1:2] rx_fifo_flush ##1 !rx_fifo_flush)
    else $error("flush pulse wrong");
  chk_tx_irq: assert property (
    tx_fifo_event && cfg_r[0] && cfg_r[3] && ien_r[0] |-> ##2 irq)
    else $error("tx irq missing");
  chk_rx_irq: assert property (
    rx_fifo_event && cfg_r[0] && cfg_r[2] && ien_r[1] |-> ##2 irq)
    else $error("rx irq missing");
  chk_enable_hold: assert property (
    !cfg_r[1] && !wr |=> $stable(rx_enable) && $stable(tx_enable))
    else $error("enables moved without auto");
  chk_rx_stop: assert property (
    cfg_r[1] && rx_full_done && mode_r[1:0] != 2'h2 |=> !rx_enable)
    else $error("rx enable not cleared");
  chk_tx_stop: assert property (
    cfg_r[1] && tx_end_done && mode_r[1:0] != 2'h1 |=> !tx_enable)
    else $error("tx enable not cleared");
  chk_both_stop: assert property (
    cfg_r[1] && mode_r[1:0] == 2'h3 && (rx_full_done || tx_end_done)
    |=> !rx_enable && !tx_enable)
    else $error("full duplex enables not cleared");
  chk_active_cfg: assert property (
    age_r == 2'h3 |-> fifo_active == (cfg_r[0] && !mode_r[2]))
    else $error("fifo active wrong");
  chk_full_split: assert property (
    age_r == 2'h3 && fifo_active && mode_r[1:0] == 2'h3 |-> tx_fifo_depth == 3'h2)
    else $error("full duplex tx depth wrong");
  chk_tx_whole: assert property (
    age_r == 2'h3 && fifo_active && mode_r[1:0] == 2'h2
    |-> tx_fifo_depth == 3'h4 && rx_fifo_depth == 3'h0)
    else $error("half tx depth wrong");
  chk_rx_whole: assert property (
    age_r == 2'h3 && fifo_active && mode_r[1:0] == 2'h1 && !cfg_r[4]
    |-> rx_fifo_depth == 3'h4)
    else $error("half rx depth wrong");
endmodule

bind sfc_top sfc_top_properties chk (
  .clk           (clk),
  .reset_n       (reset_n),
  .psel          (psel),
  .penable       (penable),
  .pwrite        (pwrite),
  .pready        (pready),
  .paddr         (paddr),
  .pwdata        (pwdata),
  .tx_fifo_event (tx_fifo_event),
  .rx_fifo_event (rx_fifo_event),
  .rx_full_done  (rx_full_done),
  .tx_end_done   (tx_end_done),
  .rx_enable     (rx_enable),
  .tx_enable     (tx_enable),
  .fifo_active   (fifo_active),
  .rx_fifo_flush (rx_fifo_flush),
  .irq           (irq),
  .rx_fifo_depth (rx_fifo_depth),
  .tx_fifo_depth (tx_fifo_depth)
);

// ===== sfc_peer.sv
// Purpose: channel-side model raising fifo and direction-end events
// Assumes: one request at a time
// Notes:   lag sets how slowly the channel answers
`timescale 1ns/10ps
module sfc_peer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] req,
  input  wire logic [1:0] lag,
  output logic      [3:0] ev
);
  logic [3:0] pend_r;
  logic [1:0] cnt_r;
  // ======
  // delayed one-cycle event pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_r <= 4'h0;
      cnt_r  <= 2'h0;
      ev     <= 4'h0;
    end else if (req != 4'h0) begin
      pend_r <= req;
      cnt_r  <= lag;
      ev     <= 4'h0;
    end else if (pend_r != 4'h0 && cnt_r == 2'h0) begin
      ev     <= pend_r;
      pend_r <= 4'h0;
    end else begin
      ev     <= 4'h0;
      cnt_r  <= cnt_r - 2'h1;
    end
  end
endmodule

// ===== test_serial_fifo_config.sv
// Purpose: self-checking bench for sfc_top
// Assumes: apb master, channel model as event source
// Notes:   fixed seed, random fill levels and channel lag
`timescale 1ns/10ps
module test_serial_fifo_config;
  logic        clk, reset_n, psel, penable, pwrite, e, u, k, a;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, irq, rx_enable, tx_enable, fifo_active, rx_fifo_flush;
  logic [2:0]  rx_fifo_depth, tx_fifo_depth;
  logic [3:0]  req;
  logic [1:0]  lag, d, f, x;
  wire  [3:0]  ev;
  wire         tx_fifo_event, rx_fifo_event, rx_full_done, tx_end_done;
  int          errors, checks_done, flushes;
  assign {tx_end_done, rx_full_done, rx_fifo_event, tx_fifo_event} = ev;
  sfc_top dut (
    .clk           (clk),
    .reset_n       (reset_n),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .tx_fifo_event (tx_fifo_event),
    .rx_fifo_event (rx_fifo_event),
    .rx_full_done  (rx_full_done),
    .tx_end_done   (tx_end_done),
    .rx_enable     (rx_enable),
    .tx_enable     (tx_enable),
    .fifo_active   (fifo_active),
    .rx_fifo_depth (rx_fifo_depth),
    .tx_fifo_depth (tx_fifo_depth),
    .rx_fifo_flush (rx_fifo_flush),
    .irq           (irq)
  );
  // flush pulse counter
  always @(posedge clk) begin
    if (!reset_n) flushes <= 0;
    else if (rx_fifo_flush) flushes <= flushes + 1;
  end
  sfc_peer peer (.clk(clk), .reset_n(reset_n), .req(req), .lag(lag), .ev(ev));
  // ======
  // expectations
  function automatic logic [5:0] dep(input logic [1:0] dd, input logic uu, input logic [1:0] ff);
    case (dd)
      2'h1: dep = {(uu && ff != 2'h0) ? {1'b0, ff} : 3'h4, 3'h0};
      2'h2: dep = 6'h04;
      2'h3: dep = {(uu && ff[0]) ? 3'h1 : 3'h2, 3'h2};
      default: dep = 6'h00;
    endcase
  endfunction
  function automatic logic [1:0] stp(input logic [1:0] dd, input logic aa, input logic kk);
    if (!aa) stp = 2'h3;
    else if (dd == 2'h3) stp = 2'h0;
    else stp = kk ? 2'h2 : 2'h1;
  endfunction
  // ======
  // tasks
  task automatic final_report;
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] xp, input logic [31:0] g);
    checks_done++;
    if (g !== xp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", s, xp, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      cmp("pready", 1, pready);
      final_report();
    end
    @(posedge clk);
  endtask
  task automatic pulse(input logic [3:0] r);
    req <= r;
    lag <= 2'($urandom);
    @(posedge clk);
    req <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
  // ======
  // clock and sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, req, lag} = '0;
    errors = 0;
    checks_done = 0;
    void'($urandom(32'h50F0));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      cmp("reset read", 32'h0, q);
      cmp("slverr", i == 7, e);
    end
    apb(1'b1, 8'h04, 32'h0000000C);
    apb(1'b1, 8'h00, 32'h00000001);
    apb(1'b1, 8'h08, 32'h00000080);
    apb(1'b0, 8'h08, 32'h0);
    cmp("clear bit", 32'h0, q);
    cmp("flush count", 1, flushes);
    for (int i = 0; i < 8; i++) begin
      d = i[2:1];
      u = i[0];
      f = 2'($urandom);
      apb(1'b1, 8'h04, {28'h0, d, 2'h0});
      apb(1'b1, 8'h08, {30'h0, f});
      apb(1'b1, 8'h00, {27'h0, u, 4'h1});
      apb(1'b0, 8'h18, 32'h0);
      cmp("depth", {26'h0, dep(d, u, f)}, q);
      cmp("depth out", {26'h0, dep(d, u, f)}, {26'h0, rx_fifo_depth, tx_fifo_depth});
      cmp("active", 1, fifo_active);
    end
    apb(1'b1, 8'h04, 32'h0000001C);
    cmp("nine bit active", 0, fifo_active);
    apb(1'b1, 8'h04, 32'h0000000C);
    apb(1'b1, 8'h10, 32'h00000003);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h00, {28'h0, i[1], i[0], 1'b0, i[2]});
      apb(1'b1, 8'h14, 32'h00000003);
      pulse(4'h3);
      x = i[2] ? {i[0], i[1]} : 2'h0;
      apb(1'b0, 8'h0C, 32'h0);
      cmp("status", x, q);
      cmp("irq", |x, irq);
    end
    apb(1'b1, 8'h10, 32'h0);
    cmp("masked irq", 0, irq);
    apb(1'b1, 8'h14, 32'h00000003);
    apb(1'b0, 8'h0C, 32'h0);
    cmp("cleared status", 0, q);
    for (int i = 0; i < 9; i++) begin
      d = i[2:1];
      k = i[0];
      a = i < 8;
      if ((d == 2'h1 && k) || (d == 2'h2 && !k)) continue;
      apb(1'b1, 8'h00, {30'h0, a, 1'b1});
      apb(1'b1, 8'h04, {28'h0, d, 2'h3});
      pulse(k ? 4'h8 : 4'h4);
      cmp("enables", stp(d, a, k), {rx_enable, tx_enable});
    end
    final_report();
  end
endmodule
